//--- design/dhcp_regs.svh
// Purpose: Register map, codes and timing counts of the DHCP mode command sequencer
// Assumes: 20 MHz mclk, classic Wishbone with 32-bit data
// Notes:   Offsets are byte addresses; each register takes one aligned word
// Function
// R1 - The disable command goes out only when its trigger goes from false to true, never on a held level.
// R2 - The enable sequence starts only on a false-to-true change of its trigger, never on a held level.
// R3 - After the enable command the module is polled once a second for a server and a valid address.
// R4 - The enable timeout is given in whole seconds between 5 and 127 and bounds the polling.
// R5 - When the timeout runs out with no address, the error bit sets and the code word reads 1005.
// R6 - Success on enable is given only after the module reports a found server and a valid address.
// R7 - A finished command shows exactly one of success or error.
// R8 - An error code is below 100 when the module failed and above 1000 when local logic failed.
// R9 - The setting is kept in the module's flash, which leaves it unavailable for half a second or more.
// R10 - The program should fire each command once, on the second scan, from the inverted first-scan flag.
// R11 - Each command names its module by a number from 0 to 255 that must match the configured number.
// R12 - The private workspace word of a command is touched by nothing else.
// R13 - The configuration block offers a result status word, an interlock word and a 130-byte buffer.
// R14 - While one command to the module runs, the interlock holds every other command back.
`ifndef DHCP_REGS_SVH
`define DHCP_REGS_SVH

// Register offsets
`define OFS_CTRL          10'h000
`define OFS_TIMEOUT       10'h004
`define OFS_CFG_NUM       10'h008
`define OFS_STATUS        10'h00c
`define OFS_ERR_CODE      10'h010
`define OFS_RESULT        10'h014
`define OFS_BUF           10'h100
`define BUF_WORDS         8'h41

// Status bits
`define ST_SUCCESS        0
`define ST_ERROR          1
`define ST_INTERLOCK      2

// Reset values and limits
`define TIMEOUT_MIN       7'h05
`define TIMEOUT_MAX       7'h7f
`define CFG_NUM_RST       8'h00

// Link command codes
`define NET_CMD_NONE      2'h0
`define NET_CMD_DISABLE   2'h1
`define NET_CMD_ENABLE    2'h2
`define NET_CMD_POLL      2'h3

// Error codes (decimal 99, 1001, 1005)
`define ERR_MOD_MAX       16'h0063
`define ERR_MOD_NUM       16'h03e9
`define ERR_TIMEOUT       16'h03ed

// Timing
`define MCLK_PERIOD_NS    50
`define POLL_PERIOD_MS    1000
`define FLASH_HOLD_MS     500
`define POLL_CYCLES       (`POLL_PERIOD_MS * 1000000 / `MCLK_PERIOD_NS)
`define FLASH_HOLD_CYCLES ((`FLASH_HOLD_MS * 1000000 + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

`endif

//--- design/dhcp_pkg.sv
// Purpose: Types of the DHCP mode command sequencer
// Assumes: Nothing beyond the register header
// Notes:   Sequencer states only; codes live in the header
package dhcp_pkg;
    typedef enum logic [2:0] {
        S_IDLE,
        S_CMD,
        S_CMD_REL,
        S_HOLD,
        S_WAIT,
        S_POLL,
        S_POLL_REL
    } state_t;
endpackage

//--- design/dhcp_mode_command_sequencer.sv
// Purpose: Issues DHCP disable and enable commands to the network module
// Assumes: Partner holds net_err and net_ip_ok steady while net_ack is high
// Notes:   One sequencer serves both commands, so the interlock is its busy state
`timescale 1ns/1ns
`include "dhcp_regs.svh"

module dhcp_mode_command_sequencer
    import dhcp_pkg::*;
#(
    parameter int unsigned POLL_CYCLES = `POLL_CYCLES,
    parameter int unsigned HOLD_CYCLES = `FLASH_HOLD_CYCLES
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic             wb_ack_o,
    output logic      [31:0] wb_dat_o,
    // Network module link
    output logic             net_req,
    output logic      [1:0]  net_cmd,
    output logic      [7:0]  net_module,
    input  wire logic        net_ack,
    input  wire logic        net_ip_ok,
    input  wire logic [6:0]  net_err,
    // Result pins
    output logic             cmd_success,
    output logic             cmd_error,
    output logic             cmd_busy
);

    localparam logic [24:0] POLL_LAST = 25'(POLL_CYCLES - 1);
    localparam logic [24:0] HOLD_LAST = 25'(HOLD_CYCLES - 1);

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] dat,
                                            input logic [1:0] sel);
        merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
    endfunction

    // Bus state
    logic        ack_reg;
    logic [31:0] dat_reg;
    // Control and result state
    logic [1:0]  trig_reg;
    logic [1:0]  trig_prev_reg;
    logic [7:0]  mod_num_reg;
    logic [7:0]  cfg_num_reg;
    logic [6:0]  timeout_reg;
    logic        dis_pend_reg;
    logic        en_pend_reg;
    logic        active_en_reg;
    logic        success_reg;
    logic        error_reg;
    logic [15:0] err_code_reg;
    logic [15:0] result_reg;
    logic [15:0] buf_mem [`BUF_WORDS];
    // Sequencer
    state_t      state_reg;
    state_t      state_next;
    logic [24:0] cnt_reg;
    logic [24:0] cnt_next;
    logic [6:0]  sec_reg;
    logic [6:0]  sec_next;
    logic        net_req_reg;
    logic        req_next;
    logic [1:0]  net_cmd_reg;
    logic [1:0]  cmd_next;
    logic [7:0]  net_module_reg;
    logic [6:0]  resp_err_reg;
    logic        resp_ip_reg;
    logic        fin_ok;
    logic        fin_err;
    logic        fin_mod;
    logic [15:0] fin_code;
    logic        launch;
    logic        busy_reg;
    // Pin synchronisers: {err, ip_ok, ack}
    logic [8:0]  sync1_reg;
    logic [8:0]  sync2_reg;

    // Bus decode
    wire        bus_take  = wb_cyc_i & wb_stb_i & ~ack_reg;
    wire        wr_stb    = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
    wire [9:0]  word_adr  = {wb_adr_i[9:2], 2'b00};
    wire [9:0]  buf_diff  = word_adr - `OFS_BUF;
    wire [6:0]  buf_idx   = buf_diff[8:2];
    wire        sel_ctrl  = word_adr == `OFS_CTRL;
    wire        sel_tmo   = word_adr == `OFS_TIMEOUT;
    wire        sel_cfg   = word_adr == `OFS_CFG_NUM;
    wire        sel_stat  = word_adr == `OFS_STATUS;
    wire        sel_code  = word_adr == `OFS_ERR_CODE;
    wire        sel_res   = word_adr == `OFS_RESULT;
    wire        buf_hit   = (word_adr >= `OFS_BUF) && (buf_diff[9:2] < `BUF_WORDS);
    wire [15:0] ctrl_word = {mod_num_reg, 6'h00, trig_reg};
    wire [15:0] ctrl_wv   = merge16(ctrl_word, wb_dat_i[15:0], wb_sel_i[1:0]);
    wire [15:0] tmo_wv    = merge16({9'h000, timeout_reg}, wb_dat_i[15:0], wb_sel_i[1:0]);
    wire [15:0] cfg_wv    = merge16({8'h00, cfg_num_reg}, wb_dat_i[15:0], wb_sel_i[1:0]);
    // Out-of-range timeouts are clamped rather than refused
    wire [6:0]  tmo_clamp = (tmo_wv < {9'h000, `TIMEOUT_MIN}) ? `TIMEOUT_MIN :  // see R4
                            (tmo_wv > {9'h000, `TIMEOUT_MAX}) ? `TIMEOUT_MAX : tmo_wv[6:0];
    wire [2:0]  status    = {state_reg != S_IDLE, error_reg, success_reg};
    wire [31:0] rd_data   = sel_ctrl ? {16'h0000, ctrl_word} :
                            sel_tmo  ? {25'h0000000, timeout_reg} :
                            sel_cfg  ? {24'h000000, cfg_num_reg} :
                            sel_stat ? {29'h00000000, status} :
                            sel_code ? {16'h0000, err_code_reg} :
                            sel_res  ? {16'h0000, result_reg} :
                            buf_hit  ? {16'h0000, buf_mem[buf_idx]} : 32'h00000000;

    // Link and sequencer decode
    wire        ack_s        = sync2_reg[0];
    wire        ip_s         = sync2_reg[1];
    wire [6:0]  err_s        = sync2_reg[8:2];
    wire        mod_fail     = resp_err_reg != 7'h00;
    wire [15:0] mod_code     = (resp_err_reg > `ERR_MOD_MAX) ? `ERR_MOD_MAX :
                               {9'h000, resp_err_reg};                       // see R8
    wire        dis_edge     = trig_reg[0] & ~trig_prev_reg[0];               // see R1
    wire        en_edge      = trig_reg[1] & ~trig_prev_reg[1];               // see R2
    wire        go           = dis_pend_reg | en_pend_reg;
    wire        num_mismatch = mod_num_reg != cfg_num_reg;
    wire        cnt_zero     = cnt_reg == 25'h0000000;
    wire        resp_take    = ack_s & ((state_reg == S_CMD) | (state_reg == S_POLL));

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_reg <= 9'h000;
            sync2_reg <= 9'h000;
        end else begin
            sync1_reg <= {net_err, net_ip_ok, net_ack};
            sync2_reg <= sync1_reg;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h00000000;
        end else begin
            ack_reg <= bus_take;
            dat_reg <= bus_take ? rd_data : dat_reg;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            trig_reg      <= 2'h0;
            trig_prev_reg <= 2'h0;
            mod_num_reg   <= 8'h00;
            cfg_num_reg   <= `CFG_NUM_RST;
            timeout_reg   <= `TIMEOUT_MIN;
        end else begin
            trig_prev_reg <= trig_reg;
            trig_reg      <= (wr_stb && sel_ctrl) ? ctrl_wv[1:0] : trig_reg;
            mod_num_reg   <= (wr_stb && sel_ctrl) ? ctrl_wv[15:8] : mod_num_reg;
            cfg_num_reg   <= (wr_stb && sel_cfg) ? cfg_wv[7:0] : cfg_num_reg;
            timeout_reg   <= (wr_stb && sel_tmo) ? tmo_clamp : timeout_reg;
        end
    end

    // Shared message buffer, 65 words
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < `BUF_WORDS; i++) begin
                buf_mem[i] <= 16'h0000;
            end
        end else if (wr_stb && buf_hit) begin
            buf_mem[buf_idx] <= merge16(buf_mem[buf_idx], wb_dat_i[15:0], wb_sel_i[1:0]);  // see R13
        end
    end

    // Edges that arrive while busy wait here; a new edge beats the launch clear
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            dis_pend_reg  <= 1'b0;
            en_pend_reg   <= 1'b0;
            active_en_reg <= 1'b0;
        end else begin
            dis_pend_reg  <= dis_edge | (dis_pend_reg & ~launch);                 // see R14
            en_pend_reg   <= en_edge | (en_pend_reg & ~(launch & ~dis_pend_reg)); // see R14
            active_en_reg <= launch ? ~dis_pend_reg : active_en_reg;
        end
    end

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        sec_next   = sec_reg;
        req_next   = net_req_reg;
        cmd_next   = net_cmd_reg;
        fin_ok     = 1'b0;
        fin_err    = 1'b0;
        fin_mod    = 1'b0;
        fin_code   = 16'h0000;
        launch     = 1'b0;
        case (state_reg)
            S_IDLE: begin
                if (go) begin
                    launch = 1'b1;                                      // see R14
                    if (num_mismatch) begin
                        fin_err  = 1'b1;                                // see R11
                        fin_code = `ERR_MOD_NUM;
                    end else begin
                        state_next = S_CMD;
                        req_next   = 1'b1;
                        cmd_next   = dis_pend_reg ? `NET_CMD_DISABLE : `NET_CMD_ENABLE;
                    end
                end
            end
            S_CMD: begin
                if (ack_s) begin
                    state_next = S_CMD_REL;
                    req_next   = 1'b0;
                end
            end
            S_CMD_REL: begin
                if (!ack_s) begin
                    if (mod_fail) begin
                        state_next = S_IDLE;
                        fin_err    = 1'b1;
                        fin_mod    = 1'b1;
                        fin_code   = mod_code;                          // see R8
                    end else begin
                        state_next = S_HOLD;                            // see R9
                        cnt_next   = HOLD_LAST;
                    end
                end
            end
            S_HOLD: begin
                if (!cnt_zero) begin
                    cnt_next = cnt_reg - 25'h0000001;
                end else if (active_en_reg) begin
                    state_next = S_WAIT;
                    cnt_next   = POLL_LAST;
                    sec_next   = 7'h00;
                end else begin
                    state_next = S_IDLE;
                    fin_ok     = 1'b1;
                end
            end
            S_WAIT: begin
                if (!cnt_zero) begin
                    cnt_next = cnt_reg - 25'h0000001;
                end else begin
                    state_next = S_POLL;                                // see R3
                    req_next   = 1'b1;
                    cmd_next   = `NET_CMD_POLL;
                    sec_next   = 7'(sec_reg + 7'h01);
                end
            end
            S_POLL: begin
                if (ack_s) begin
                    state_next = S_POLL_REL;
                    req_next   = 1'b0;
                end
            end
            S_POLL_REL: begin
                if (!ack_s) begin
                    state_next = S_IDLE;
                    if (mod_fail) begin
                        fin_err  = 1'b1;
                        fin_mod  = 1'b1;
                        fin_code = mod_code;
                    end else if (resp_ip_reg) begin
                        fin_ok = 1'b1;                                  // see R6
                    end else if (sec_reg >= timeout_reg) begin
                        fin_err  = 1'b1;                                // see R5
                        fin_code = `ERR_TIMEOUT;
                    end else begin
                        state_next = S_WAIT;
                        cnt_next   = POLL_LAST;
                    end
                end
            end
            default: begin
                state_next = S_IDLE;
                req_next   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg      <= S_IDLE;
            cnt_reg        <= 25'h0000000;
            sec_reg        <= 7'h00;
            net_req_reg    <= 1'b0;
            net_cmd_reg    <= `NET_CMD_NONE;
            net_module_reg <= 8'h00;
            resp_err_reg   <= 7'h00;
            resp_ip_reg    <= 1'b0;
            busy_reg       <= 1'b0;
        end else begin
            state_reg      <= state_next;
            cnt_reg        <= cnt_next;
            sec_reg        <= sec_next;
            net_req_reg    <= req_next;
            net_cmd_reg    <= cmd_next;
            net_module_reg <= launch ? mod_num_reg : net_module_reg;
            resp_err_reg   <= resp_take ? err_s : resp_err_reg;
            resp_ip_reg    <= resp_take ? ip_s : resp_ip_reg;
            busy_reg       <= state_next != S_IDLE;                      // see R14
        end
    end

    // Launch clears both bits; completion sets exactly one and wins over launch
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            success_reg  <= 1'b0;
            error_reg    <= 1'b0;
            err_code_reg <= 16'h0000;
            result_reg   <= 16'h0000;
        end else begin
            success_reg  <= fin_ok | (success_reg & ~launch);                // see R7
            error_reg    <= fin_err | (error_reg & ~launch);                 // see R7
            err_code_reg <= fin_err ? fin_code : (fin_ok ? 16'h0000 : err_code_reg);
            result_reg   <= (fin_ok | fin_err) ? fin_code : result_reg;      // see R13
        end
    end

    assign wb_ack_o    = ack_reg;
    assign wb_dat_o    = dat_reg;
    assign net_req     = net_req_reg;
    assign net_cmd     = net_cmd_reg;
    assign net_module  = net_module_reg;
    assign cmd_success = success_reg;
    assign cmd_error   = error_reg;
    assign cmd_busy    = busy_reg;

    default clocking dc @(posedge mclk); endclocking
    default disable iff (!arst_n);

    chk_dis_edge_only: assert property ($rose(dis_pend_reg) |-> $past(dis_edge)) // see R1
        else $error("disable pending without rising trigger");
    chk_en_edge_only: assert property ($rose(en_pend_reg) |-> $past(en_edge)) // see R2
        else $error("enable pending without rising trigger");
    chk_poll_after_second: assert property ( // see R3
        $rose(net_req_reg) && net_cmd_reg == `NET_CMD_POLL
            |-> $past(state_reg) == S_WAIT && $past(cnt_reg) == 25'h0000000)
        else $error("poll issued before the second ran out");
    chk_timeout_range: assert property (timeout_reg >= `TIMEOUT_MIN) // see R4
        else $error("timeout below its least value");
    chk_timeout_code: assert property ( // see R5
        state_reg == S_POLL_REL && !ack_s && !mod_fail && !resp_ip_reg
            && sec_reg >= timeout_reg
            |=> error_reg && !success_reg && err_code_reg == `ERR_TIMEOUT)
        else $error("timeout did not report its code");
    chk_success_cause: assert property ($rose(success_reg) |-> // see R6
        ($past(state_reg) == S_POLL_REL && $past(resp_ip_reg))
            || ($past(state_reg) == S_HOLD && !$past(active_en_reg)))
        else $error("success without module confirmation");
    chk_one_result: assert property ((fin_ok || fin_err) |=> success_reg != error_reg) // see R7
        else $error("completion did not show exactly one result");
    chk_mod_code_low: assert property (fin_err && fin_mod // see R8
        |=> err_code_reg < 16'h0064 && err_code_reg != 16'h0000)
        else $error("module error code out of range");
    chk_logic_code_high: assert property (fin_err && !fin_mod |=> err_code_reg > 16'h03e8) // see R8
        else $error("local error code out of range");
    chk_flash_hold: assert property ( // see R9
        state_reg == S_HOLD && cnt_reg != 25'h0000000 |=> state_reg == S_HOLD && !net_req_reg)
        else $error("flash hold cut short");
    chk_module_match: assert property ($rose(net_req_reg) |-> net_module_reg == cfg_num_reg) // see R11
        else $error("command sent to an unconfigured module number");
    chk_interlock_hold: assert property ( // see R14
        $rose(net_req_reg) && net_cmd_reg != `NET_CMD_POLL |-> $past(state_reg) == S_IDLE)
        else $error("command launched while another was pending");

    cov_disable_ok: cover property ($rose(success_reg) && !active_en_reg);
    cov_enable_ok: cover property ($rose(success_reg) && active_en_reg);
    cov_timeout: cover property ($rose(error_reg) && err_code_reg == `ERR_TIMEOUT);
    cov_mismatch: cover property (launch && num_mismatch);

endmodule

//--- bench/net_module_model.sv
// Purpose: Network module on the far side of the command link
// Assumes: Four-phase link; answer held while ack is high
// Notes:   Idle answer lines toggle so a stale value never passes
`timescale 1ns/1ns

module net_module_model (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       arst_n,
    // Link
    input  wire logic       net_req,
    input  wire logic [1:0] net_cmd,
    output logic            net_ack,
    output logic            net_ip_ok,
    output logic      [6:0] net_err,
    // Scenario
    input  wire logic [7:0] ok_poll,
    input  wire logic [6:0] err_val,
    input  wire logic [3:0] delay
);
    int polls;
    int waits;

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            net_ack   <= 1'b0;
            net_ip_ok <= 1'b0;
            net_err   <= 7'h00;
            polls     <= 0;
            waits     <= 0;
        end else if (net_ack) begin
            net_ack <= net_req;
        end else if (net_req && waits >= delay) begin
            net_ack   <= 1'b1;
            net_ip_ok <= net_cmd == 2'h3 && polls + 1 == ok_poll;
            net_err   <= err_val;
            polls     <= (net_cmd == 2'h3) ? polls + 1 : 0;
            waits     <= 0;
        end else begin
            net_ip_ok <= ~net_ip_ok;
            net_err   <= ~net_err;
            waits     <= net_req ? waits + 1 : 0;
        end
    end
endmodule

//--- bench/dhcp_mode_command_sequencer_tb_top.sv
// Purpose: Self-checking bench of the DHCP mode command sequencer
// Assumes: Poll and hold counts cut to 20 and 10 cycles
// Notes:   Seeded module numbers, codes and answer delays
`timescale 1ns/1ns
`include "dhcp_regs.svh"

module dhcp_mode_command_sequencer_tb_top import dhcp_pkg::*;;
    localparam int POLL = 20;
    localparam int HOLD = 10;
    logic        mclk = 1'b0, arst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic        wb_ack_o, net_req, net_ack, net_ip_ok, cmd_success, cmd_error, cmd_busy;
    logic        req_q = 1'b0;
    logic [1:0]  net_cmd, last_cmd;
    logic [3:0]  delay = 4'h0, wb_sel_i = 4'h0, bsel = 4'hf;
    logic [6:0]  net_err, err_val = 7'h00;
    logic [7:0]  net_module, ok_poll = 8'h00, num = 8'h00;
    logic [9:0]  wb_adr_i = 10'h000;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, seed = 32'h7fc5;
    int          mismatches, checked, cyc_n, last_rise;
    int          reqs [4];

    dhcp_mode_command_sequencer #(.POLL_CYCLES(POLL), .HOLD_CYCLES(HOLD)) u_dut (
        .mclk(mclk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .net_req(net_req), .net_cmd(net_cmd),
        .net_module(net_module), .net_ack(net_ack), .net_ip_ok(net_ip_ok),
        .net_err(net_err), .cmd_success(cmd_success), .cmd_error(cmd_error),
        .cmd_busy(cmd_busy));

    net_module_model u_net (
        .mclk(mclk), .arst_n(arst_n), .net_req(net_req), .net_cmd(net_cmd),
        .net_ack(net_ack), .net_ip_ok(net_ip_ok), .net_err(net_err),
        .ok_poll(ok_poll), .err_val(err_val), .delay(delay));

    initial begin
        forever #25 mclk = ~mclk;
    end

    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        tally_and_finish();
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] clamp_to(input logic [31:0] v);
        return (v < 32'd5) ? 32'd5 : (v > 32'd127) ? 32'd127 : v;
    endfunction

    // First poll also waits out the flash hold
    function automatic logic in_gap(input int g);
        int lo;
        lo = (last_cmd == 2'h2) ? HOLD + POLL : POLL;
        return g >= lo && g <= lo + 40;
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc_n++;
        req_q <= net_req;
        if (net_req && !req_q) begin
            reqs[net_cmd]++;
            chk("link module", {24'h0, num}, {24'h0, net_module});
            if (net_cmd == 2'h3) begin
                chk("poll gap", 32'h1, {31'h0, in_gap(cyc_n - last_rise)});
            end
            last_rise = cyc_n;
            last_cmd = net_cmd;
        end
    end

    task automatic bus(input logic we, input logic [9:0] adr, input logic [31:0] dat);
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= bsel;
        wb_dat_i <= dat;
        do begin
            @(posedge mclk);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic rdchk(input string what, input logic [9:0] adr, input logic [31:0] exp);
        bus(1'b0, adr, 32'h0);
        chk(what, exp, rd);
    endtask

    // Busy may drop for a cycle between a finish and a pending launch
    task automatic wait_idle();
        int quiet;
        int n;
        quiet = 0;
        n = 0;
        repeat (3) @(posedge mclk);
        while (quiet < 4 && n < 5000) begin
            @(posedge mclk);
            n++;
            quiet = cmd_busy ? 0 : quiet + 1;
        end
    endtask

    task automatic run(input logic [1:0] trig, input logic [7:0] mnum);
        bus(1'b1, `OFS_CTRL, {16'h0, mnum, 8'h00});
        bus(1'b1, `OFS_CTRL, {16'h0, mnum, 6'h0, trig});
        wait_idle();
    endtask

    task automatic done(input logic ok, input logic [15:0] code);
        chk("success pin", {31'h0, ok}, {31'h0, cmd_success});
        chk("error pin", {31'h0, !ok}, {31'h0, cmd_error});
        chk("busy pin", 32'h0, {31'h0, cmd_busy});
        rdchk("error code", `OFS_ERR_CODE, {16'h0, code});
    endtask

    initial begin
        logic [31:0] w;
        int          p;
        int          q;
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        rdchk("timeout reset", `OFS_TIMEOUT, 32'h5);
        bus(1'b1, `OFS_STATUS, 32'hffff);
        rdchk("status", `OFS_STATUS, 32'h0);
        rdchk("unmapped", 10'h020, 32'h0);
        for (int i = 0; i < 4; i++) begin
            w = (i == 0) ? 32'd4 : (i == 1) ? 32'd5 : (i == 2) ? 32'd127 : (xs() & 32'h7f);
            bus(1'b1, `OFS_TIMEOUT, w);
            rdchk("timeout", `OFS_TIMEOUT, clamp_to(w));
        end
        bsel = 4'h1;
        bus(1'b1, `OFS_TIMEOUT, 32'h0000ff10);
        bsel = 4'hf;
        rdchk("timeout bytes", `OFS_TIMEOUT, 32'h10);
        for (int k = 0; k < 3; k++) begin
            p = (k == 0) ? 0 : (k == 1) ? 64 : (xs() % 63) + 1;
            w = xs() & 32'hffff;
            bus(1'b1, 10'(`OFS_BUF + 4 * p), w);
            rdchk("buffer", 10'(`OFS_BUF + 4 * p), w);
        end
        w = xs();
        num = w[7:0];
        bus(1'b1, `OFS_CFG_NUM, {24'h0, num});
        rdchk("cfg number", `OFS_CFG_NUM, {24'h0, num});
        delay <= 4'(xs());
        p = reqs[1];
        run(2'b01, num);
        done(1'b1, 16'h0);
        bus(1'b1, `OFS_CTRL, {16'h0, num, 8'h01});
        wait_idle();
        chk("disable count", p + 1, reqs[1]);
        ok_poll <= 8'd2;
        p = reqs[2];
        q = reqs[3];
        run(2'b10, num);
        done(1'b1, 16'h0);
        chk("enable count", p + 1, reqs[2]);
        chk("polls to ok", q + 2, reqs[3]);
        w = 32'd5 + (xs() & 32'h3);
        bus(1'b1, `OFS_TIMEOUT, w);
        ok_poll <= 8'd0;
        q = reqs[3];
        run(2'b10, num);
        done(1'b0, `ERR_TIMEOUT);
        chk("polls to timeout", q + w, reqs[3]);
        rdchk("result", `OFS_RESULT, {16'h0, `ERR_TIMEOUT});
        for (int i = 0; i < 2; i++) begin
            w = i ? (xs() % 98) + 1 : 32'd99;
            err_val <= w[6:0];
            delay <= 4'(xs());
            run(i ? 2'b10 : 2'b01, num);
            done(1'b0, w[15:0]);
        end
        err_val <= 7'h00;
        p = reqs[1];
        run(2'b01, num ^ 8'h5a);
        done(1'b0, `ERR_MOD_NUM);
        chk("mismatch link", p, reqs[1]);
        ok_poll <= 8'd1;
        run(2'b00, num);
        bus(1'b1, `OFS_CTRL, {16'h0, num, 8'h02});
        repeat (3) @(posedge mclk);
        rdchk("busy", `OFS_STATUS, 32'h4);
        chk("busy pin", 32'h1, {31'h0, cmd_busy});
        bus(1'b1, `OFS_CTRL, {16'h0, num, 8'h03});
        chk("held off", p, reqs[1]);
        wait_idle();
        chk("pending disable", p + 1, reqs[1]);
        done(1'b1, 16'h0);
        tally_and_finish();
    end
endmodule
